// [verilog/pcc_pwm_cycle_config.sv]
// pwm cycle configuration register, overflow flag and compare/reload steering
// What this block does
// [RULE1] select bit 0 steers compare addresses to compare bank, 1 to reload bank
// [RULE2] in 9, 10, 11-bit pwm the reload bank reloads the module compare
// [RULE3] reload bank has no effect in other modes yet stays read/writable
// [RULE4] irq enable masks the cycle overflow flag onto the irq request
// [RULE5] flag sets when counter wraps at bit 8, 9, 10 or 11 as selected
// [RULE6] flag set by hardware or software; only a software zero clears it
// [RULE7] select codes 00, 01, 10 give 8, 9 and 10-bit cycles
// [RULE8] chosen cycle length applies to all non-wide pwm channels together
// [RULE9] wide channels ignore the select field and use 16 bits
// [RULE10] bits 4 to 2 read zero and ignore writes
// [RULE11] config resets to zero, lives at address D9 on page 0F
// [RULE12] per-module wide enable picks 16-bit cycle over shared 8-11 bit
// [RULE13] select code 11 gives an 11-bit cycle
`timescale 1ns/10ps
module pcc_pwm_cycle_config
  import pcc_pkg::*;
#(
  parameter int N_MODULES = 6
) (
  // clock, reset, enable
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  // special-function register port
  input  wire logic [7:0]               sfr_addr,
  input  wire logic [7:0]               sfr_page,
  input  wire logic                     sfr_wr,
  input  wire logic                     sfr_rd,
  input  wire logic [7:0]               sfr_wdata,
  output logic      [7:0]               sfr_rdata,
  output logic                          sfr_rvalid,
  // counter array view
  input  wire logic [15:0]              main_array_counter,
  input  wire logic                     counter_tick,
  input  wire logic [N_MODULES-1:0]     module_pwm_enable,
  input  wire logic [N_MODULES-1:0]     wide_pwm_enable,
  // results to the pwm modules
  output logic      [N_MODULES*16-1:0]  module_compare_register,
  output logic      [N_MODULES*5-1:0]   module_cycle_bits,
  output logic                          cycle_overflow_flag,
  output logic                          counter_array_irq
);
  localparam int ENTRIES = 2 * N_MODULES;
  localparam int AW      = $clog2(ENTRIES);

  logic                     reload_register_select_reg;
  logic                     cycle_overflow_irq_enable_reg;
  logic [1:0]               cycle_length_select_reg;
  logic [7:0]               cfg_value;
  logic                     cfg_hit;
  logic                     cmp_hit;
  logic [AW-1:0]            cmp_entry;
  logic                     ovf_event;
  logic [N_MODULES-1:0]     reload_now;
  logic [ENTRIES-1:0]       load_mask;
  logic [ENTRIES*8-1:0]     arl_contents;
  logic [7:0]               cmp_rd_data;
  logic [7:0]               arl_rd_data;
  pcc_src_type              rd_src_reg;
  pcc_src_type              rd_src_next;

  // address decode of the configuration register
  // [RULE11] fixed address and page
  assign cfg_hit = (sfr_addr == CFG_ADDR) && (sfr_page == CFG_PAGE);

  // address decode of the per-module compare bytes
  always_comb begin
    cmp_hit   = 1'b0;
    cmp_entry = '0;
    for (int n = 0; n < N_MODULES; n++) begin
      if (sfr_page == CMP_PAGE && sfr_addr == 8'(int'(CMP_LO_BASE) + n)) begin
        cmp_hit   = 1'b1;
        cmp_entry = AW'(2 * n);
      end
      if (sfr_page == CMP_PAGE && sfr_addr == 8'(int'(CMP_HI_BASE) + n)) begin
        cmp_hit   = 1'b1;
        cmp_entry = AW'(2 * n + 1);
      end
    end
  end

  // configuration fields other than the flag
  // [RULE11] all fields clear on reset
  always_ff @(posedge clk) begin
    if (rst) begin
      reload_register_select_reg    <= CFG_RESET[RELOAD_SEL_BIT];
      cycle_overflow_irq_enable_reg <= CFG_RESET[IRQ_EN_BIT];
      cycle_length_select_reg       <= CFG_RESET[LEN_SEL_LSB +: LEN_SEL_W];
    end else if (ce && sfr_wr && cfg_hit) begin
      reload_register_select_reg    <= sfr_wdata[RELOAD_SEL_BIT];
      cycle_overflow_irq_enable_reg <= sfr_wdata[IRQ_EN_BIT];
      cycle_length_select_reg       <= sfr_wdata[LEN_SEL_LSB +: LEN_SEL_W];
    end
  end

  // cycle overflow flag: sticky, a wrap in the clearing cycle still sets it
  // [RULE6] software may set or clear, hardware only sets
  always_ff @(posedge clk) begin
    if (rst) begin
      cycle_overflow_flag <= CFG_RESET[FLAG_BIT];
    end else if (ce) begin
      if (sfr_wr && cfg_hit) begin
        cycle_overflow_flag <= sfr_wdata[FLAG_BIT] | ovf_event;
      end else if (ovf_event) begin
        // [RULE5] wrap at the selected bit sets the flag
        cycle_overflow_flag <= 1'b1;
      end
    end
  end

  // interrupt request follows the flag through its mask
  // [RULE4] enable gates the flag onto the irq
  always_ff @(posedge clk) begin
    if (rst) begin
      counter_array_irq <= 1'b0;
    end else if (ce) begin
      counter_array_irq <= cycle_overflow_flag & cycle_overflow_irq_enable_reg;
    end
  end

  // readable image of the configuration register
  // [RULE10] unused bits always read zero
  always_comb begin
    cfg_value                          = '0;
    cfg_value[RELOAD_SEL_BIT]          = reload_register_select_reg;
    cfg_value[IRQ_EN_BIT]              = cycle_overflow_irq_enable_reg;
    cfg_value[FLAG_BIT]                = cycle_overflow_flag;
    cfg_value[LEN_SEL_LSB +: LEN_SEL_W] = cycle_length_select_reg;
  end

  // wrap detector for the shared cycle length
  // [RULE7] [RULE13] select code picks the wrap bit
  pcc_ovf_det u_ovf (
    .clk                 (clk),
    .rst                 (rst),
    .ce                  (ce),
    .counter             (main_array_counter),
    .counter_tick        (counter_tick),
    .cycle_length_select (cycle_length_select_reg),
    .ovf_event           (ovf_event)
  );

  // per-module reload at each cycle wrap, only for 9 to 11-bit pwm
  for (genvar n = 0; n < N_MODULES; n++) begin : g_reload
    // [RULE2] [RULE3] reload only in 9, 10 or 11-bit pwm
    assign reload_now[n] = ovf_event && module_pwm_enable[n] && !wide_pwm_enable[n]
                           && (cycle_length_select_reg != LEN_SEL_8);
    assign load_mask[2*n]     = reload_now[n];
    assign load_mask[2*n + 1] = reload_now[n];
  end

  // capture/compare bank, reloaded from the auto-reload bank
  // [RULE1] written only while the select bit is clear
  pcc_bank #(
    .ENTRIES (ENTRIES),
    .WIDTH   (8),
    .AW      (AW)
  ) u_cmp (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .wr_en     (sfr_wr && cmp_hit && !reload_register_select_reg),
    .wr_addr   (cmp_entry),
    .wr_data   (sfr_wdata),
    .rd_en     (sfr_rd && cmp_hit),
    .rd_addr   (cmp_entry),
    .rd_data   (cmp_rd_data),
    .load_mask (load_mask),
    .load_data (arl_contents),
    .contents  (module_compare_register)
  );

  // auto-reload bank, reachable only while the select bit is set
  // [RULE1] same addresses, other bank
  pcc_bank #(
    .ENTRIES (ENTRIES),
    .WIDTH   (8),
    .AW      (AW)
  ) u_arl (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .wr_en     (sfr_wr && cmp_hit && reload_register_select_reg),
    .wr_addr   (cmp_entry),
    .wr_data   (sfr_wdata),
    .rd_en     (sfr_rd && cmp_hit),
    .rd_addr   (cmp_entry),
    .rd_data   (arl_rd_data),
    .load_mask ('0),
    .load_data ('0),
    .contents  (arl_contents)
  );

  // source of a read, chosen at the request edge
  always_comb begin
    rd_src_next = SRC_NONE;
    if (sfr_rd && cfg_hit) begin
      rd_src_next = SRC_CFG;
    end else if (sfr_rd && cmp_hit) begin
      rd_src_next = reload_register_select_reg ? SRC_ARL : SRC_CMP;
    end
  end

  // read pipeline stage one: remember source and request
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_src_reg <= SRC_NONE;
    end else if (ce) begin
      rd_src_reg <= rd_src_next;
    end
  end

  // read pipeline stage two: data and valid from flops; unmapped reads keep the last data, valid low
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata  <= '0;
      sfr_rvalid <= 1'b0;
    end else if (ce) begin
      sfr_rvalid <= 1'b0;
      if (sfr_rd && !cfg_hit && !cmp_hit) begin
        sfr_rvalid <= 1'b0;
      end
      case (rd_src_reg)
        SRC_CFG: begin
          sfr_rdata  <= cfg_value;
          sfr_rvalid <= 1'b1;
        end
        SRC_CMP: begin
          sfr_rdata  <= cmp_rd_data;
          sfr_rvalid <= 1'b1;
        end
        SRC_ARL: begin
          sfr_rdata  <= arl_rd_data;
          sfr_rvalid <= 1'b1;
        end
        default: begin
          sfr_rdata <= sfr_rdata;
        end
      endcase
    end
  end

  // cycle length seen by each module; wide modules are fixed at 16 bits
  for (genvar n = 0; n < N_MODULES; n++) begin : g_len
    // [RULE8] [RULE9] [RULE12] shared length unless wide
    always_ff @(posedge clk) begin
      if (rst) begin
        module_cycle_bits[5*n +: 5] <= LEN_BASE;
      end else if (ce) begin
        module_cycle_bits[5*n +: 5] <= wide_pwm_enable[n] ? LEN_WIDE
                                       : LEN_BASE + 5'(cycle_length_select_reg);
      end
    end
  end

  // checks on the behaviour above
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_ovf_seen;
    ce && ovf_event;
  endsequence

  sequence s_cfg_write;
    ce && sfr_wr && cfg_hit;
  endsequence

  property p_flag_set;
    s_ovf_seen |=> cycle_overflow_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) // [RULE5]
    else $error("overflow did not set the flag");

  property p_flag_sticky;
    $fell(cycle_overflow_flag) |-> $past(ce && sfr_wr && cfg_hit && !sfr_wdata[FLAG_BIT]);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) // [RULE6]
    else $error("flag cleared without software write of zero");

  property p_irq_mask;
    s_cfg_write ##1 ce |=> (counter_array_irq
                            == ($past(sfr_wdata[IRQ_EN_BIT], 2) && $past(cycle_overflow_flag)));
  endproperty
  a_irq_mask: assert property (p_irq_mask) // [RULE4]
    else $error("irq does not follow masked flag");

  property p_unused_zero;
    sfr_rvalid && $past(rd_src_reg == SRC_CFG) |-> sfr_rdata[FLAG_BIT-1:LEN_SEL_W] == '0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) // [RULE10]
    else $error("unused configuration bits read nonzero");

  property p_reset_zero;
    $past(rst) |-> (cfg_value == CFG_RESET);
  endproperty
  a_reset_zero: assert property (p_reset_zero) // [RULE11]
    else $error("configuration not zero after reset");

  property p_reload_register_select_steer;
    ce && sfr_wr && cmp_hit && reload_register_select_reg && (load_mask == '0)
      |=> $stable(module_compare_register);
  endproperty
  a_reload_register_select_steer: assert property (p_reload_register_select_steer) // [RULE1]
    else $error("reload-bank write changed a compare register");

  property p_reload;
    s_ovf_seen ##0 reload_now[1] |=> module_compare_register[31:16] == $past(arl_contents[31:16]);
  endproperty
  a_reload: assert property (p_reload) // [RULE2]
    else $error("compare not reloaded on cycle wrap");

  property p_no_reload_8bit;
    s_ovf_seen ##0 (cycle_length_select_reg == LEN_SEL_8) ##0 !sfr_wr
      |=> $stable(module_compare_register);
  endproperty
  a_no_reload_8bit: assert property (p_no_reload_8bit) // [RULE3]
    else $error("reload bank acted in 8-bit mode");

  property p_cycle_len;
    ce |=> module_cycle_bits[4:0] == ($past(wide_pwm_enable[0]) ? LEN_WIDE
           : LEN_BASE + 5'($past(cycle_length_select_reg)));
  endproperty
  a_cycle_len: assert property (p_cycle_len) // [RULE9]
    else $error("module 0 cycle length wrong");

endmodule : pcc_pwm_cycle_config

// [pkg/pcc_pkg.sv]
// shared constants and types for the pwm cycle configuration block
package pcc_pkg;

  // special-function addressing of the configuration register
  localparam logic [7:0] CFG_ADDR    = 8'hD9;
  localparam logic [7:0] CFG_PAGE    = 8'h0F;
  localparam logic [7:0] CFG_RESET   = 8'h00;

  // per-module compare byte addresses (low bytes, then high bytes)
  localparam logic [7:0] CMP_PAGE    = 8'h00;
  localparam logic [7:0] CMP_LO_BASE = 8'hE0;
  localparam logic [7:0] CMP_HI_BASE = 8'hE8;

  // configuration field positions
  localparam int RELOAD_SEL_BIT = 7;
  localparam int IRQ_EN_BIT     = 6;
  localparam int FLAG_BIT       = 5;
  localparam int LEN_SEL_LSB    = 0;
  localparam int LEN_SEL_W      = 2;

  // cycle-length select codes
  localparam logic [1:0] LEN_SEL_8  = 2'h0;
  localparam logic [1:0] LEN_SEL_9  = 2'h1;
  localparam logic [1:0] LEN_SEL_10 = 2'h2;
  localparam logic [1:0] LEN_SEL_11 = 2'h3;

  // counter masks for the overflow bit of each cycle length
  localparam logic [15:0] MASK_8  = 16'h00FF;
  localparam logic [15:0] MASK_9  = 16'h01FF;
  localparam logic [15:0] MASK_10 = 16'h03FF;
  localparam logic [15:0] MASK_11 = 16'h07FF;

  // cycle length reported per module, in bits
  localparam logic [4:0] LEN_BASE = 5'h08;
  localparam logic [4:0] LEN_WIDE = 5'h10;

  // source of a pending register read
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_CFG,
    SRC_CMP,
    SRC_ARL
  } pcc_src_type;

endpackage : pcc_pkg

// [verilog/pcc_bank.sv]
// byte-wide register bank with registered read and bulk hardware load
`timescale 1ns/10ps
module pcc_bank #(
  parameter int ENTRIES = 12,
  parameter int WIDTH   = 8,
  parameter int AW      = 4
) (
  // clock and control
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  // software write port
  input  wire logic                       wr_en,
  input  wire logic [AW-1:0]              wr_addr,
  input  wire logic [WIDTH-1:0]           wr_data,
  // software read port
  input  wire logic                       rd_en,
  input  wire logic [AW-1:0]              rd_addr,
  output logic      [WIDTH-1:0]           rd_data,
  // hardware bulk load
  input  wire logic [ENTRIES-1:0]         load_mask,
  input  wire logic [ENTRIES*WIDTH-1:0]   load_data,
  // all entries in parallel
  output logic      [ENTRIES*WIDTH-1:0]   contents
);
  logic [WIDTH-1:0] mem_reg [ENTRIES];

  // one storage word per entry; a hardware load beats a software write
  for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
    always_ff @(posedge clk) begin
      if (rst) begin
        mem_reg[i] <= '0;
      end else if (ce) begin
        if (load_mask[i]) begin
          mem_reg[i] <= load_data[i*WIDTH +: WIDTH];
        end else if (wr_en && wr_addr == AW'(i)) begin
          mem_reg[i] <= wr_data;
        end
      end
    end
    assign contents[i*WIDTH +: WIDTH] = mem_reg[i];
  end

  // read data leave through a register, out-of-range reads give zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= '0;
    end else if (ce && rd_en) begin
      rd_data <= (int'(rd_addr) < ENTRIES) ? mem_reg[rd_addr] : '0;
    end
  end

endmodule : pcc_bank

// [verilog/pcc_ovf_det.sv]
// detects the counter wrap at the selected pwm cycle length
`timescale 1ns/10ps
module pcc_ovf_det
  import pcc_pkg::*;
(
  // clock and control
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // counter view
  input  wire logic [15:0] counter,
  input  wire logic        counter_tick,
  input  wire logic [1:0]  cycle_length_select,
  // one-cycle overflow event
  output logic             ovf_event
);
  logic [15:0] mask;

  // low bits that must all be ones for the next tick to wrap
  always_comb begin
    case (cycle_length_select)
      LEN_SEL_8:  mask = MASK_8;
      LEN_SEL_9:  mask = MASK_9;
      LEN_SEL_10: mask = MASK_10;
      LEN_SEL_11: mask = MASK_11;
      default:  mask = MASK_8;
    endcase
  end

  // event is registered so the flag and reloads see a clean pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      ovf_event <= 1'b0;
    end else if (ce) begin
      ovf_event <= counter_tick && ((counter & mask) == mask);
    end
  end

endmodule : pcc_ovf_det

// [sim/pcc_pwm_cycle_config_bench.sv]
// self-checking bench for the pwm cycle configuration block
`timescale 1ns/10ps
module pcc_pwm_cycle_config_bench;
  import pcc_pkg::*;
  localparam int NM         = 6;
  localparam int MAX_CYCLES = 20000;

  logic              clk       = 1'b0;
  logic              rst       = 1'b1;
  logic              ce        = 1'b1;
  logic [7:0]        sfr_addr  = 8'h00;
  logic [7:0]        sfr_page  = 8'h00;
  logic              sfr_wr    = 1'b0;
  logic              sfr_rd    = 1'b0;
  logic [7:0]        sfr_wdata = 8'h00;
  logic [7:0]        sfr_rdata;
  logic              sfr_rvalid;
  logic [15:0]       cnt       = 16'h0000;
  logic              tick_in   = 1'b0;
  logic [NM-1:0]     pwm_en    = '0;
  logic [NM-1:0]     wide_en   = '0;
  logic [NM*16-1:0]  cmp_out;
  logic [NM*5-1:0]   bits_out;
  logic              flag;
  logic              irq;
  int                bad_count  = 0;
  int                num_checks = 0;
  int                cyc_count  = 0;
  logic [15:0]       cmp_exp [NM];
  logic [15:0]       arl_exp [NM];
  logic [7:0]        d;
  logic [7:0]        last;
  logic [7:0]        w;
  logic [15:0]       m;
  logic [15:0]       rw;
  logic              v;
  logic [7:0]        tbl [5] = '{8'h20, 8'h60, 8'hE0, 8'h40, 8'h00};
  int unsigned       seed;

  pcc_pwm_cycle_config dut (
    .clk(clk), .rst(rst), .ce(ce),
    .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
    .main_array_counter(cnt), .counter_tick(tick_in),
    .module_pwm_enable(pwm_en), .wide_pwm_enable(wide_en),
    .module_compare_register(cmp_out), .module_cycle_bits(bits_out),
    .cycle_overflow_flag(flag), .counter_array_irq(irq)
  );

  // free-running clock, 25 ns period
  always #12.5 clk = ~clk;

  // hang guard: a run this long means a handshake never came
  always @(posedge clk) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == MAX_CYCLES) begin
      bad_count++;
      end_sim();
    end
  end

  // expected cycle length for one module
  function automatic logic [4:0] bits_exp(input logic [1:0] c, input logic wide);
    return wide ? 5'h10 : (5'h08 + {3'h0, c});
  endfunction : bits_exp

  // low counter bits that must all be ones for a wrap
  function automatic logic [15:0] mask_of(input logic [1:0] c);
    return (16'h0001 << (8 + c)) - 16'h0001;
  endfunction : mask_of

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  // one-cycle write strobe, launched just after an edge
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] p, input logic [7:0] dat);
    @(posedge clk);
    #2 sfr_addr = a;
    sfr_page  = p;
    sfr_wdata = dat;
    sfr_wr    = 1'b1;
    @(posedge clk);
    #2 sfr_wr = 1'b0;
  endtask : sfr_write

  // one-cycle read strobe, then a bounded wait for the answer
  task automatic sfr_read(input logic [7:0] a, input logic [7:0] p,
                          output logic [7:0] dat, output logic ok);
    int i;
    @(posedge clk);
    #2 sfr_addr = a;
    sfr_page = p;
    sfr_rd   = 1'b1;
    @(posedge clk);
    #2 sfr_rd = 1'b0;
    ok  = 1'b0;
    dat = sfr_rdata;
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      #1;
      if (sfr_rvalid === 1'b1) begin
        ok  = 1'b1;
        dat = sfr_rdata;
      end
    end
  endtask : sfr_read

  task automatic wr_word(input int n, input logic [15:0] val);
    sfr_write(8'(CMP_LO_BASE + n), CMP_PAGE, val[7:0]);
    sfr_write(8'(CMP_HI_BASE + n), CMP_PAGE, val[15:8]);
  endtask : wr_word

  task automatic rd_word(input int n, output logic [15:0] val);
    logic ok;
    sfr_read(8'(CMP_LO_BASE + n), CMP_PAGE, val[7:0], ok);
    sfr_read(8'(CMP_HI_BASE + n), CMP_PAGE, val[15:8], ok);
  endtask : rd_word

  // one counter step at a chosen value, then the settle time of the flag
  task automatic tick(input logic [15:0] val);
    @(posedge clk);
    #2 cnt = val;
    tick_in = 1'b1;
    @(posedge clk);
    #2 tick_in = 1'b0;
    cnt = 16'($urandom);
    idle(3);
  endtask : tick

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  // main sequence
  initial begin
    seed = $urandom(92243);
    repeat (12) @(posedge clk);
    #2 rst = 1'b0;
    sfr_read(CFG_ADDR, CFG_PAGE, d, v);
    chk_bit(v, 1'b1);
    chk_byte(d, CFG_RESET);
    chk_bit(flag, 1'b0);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      w = (k == 0) ? 8'hFF : 8'($urandom);
      sfr_write(CFG_ADDR, CFG_PAGE, w);
      sfr_read(CFG_ADDR, CFG_PAGE, d, v);
      chk_byte(d, w & 8'hE3);
    end
    last = d;
    sfr_read(8'hD8, CFG_PAGE, d, v);
    chk_bit(v, 1'b0);
    chk_byte(d, last);
    $display("test reserved done");
    foreach (tbl[k]) begin
      sfr_write(CFG_ADDR, CFG_PAGE, tbl[k]);
      idle(30);
      chk_bit(flag, tbl[k][5]);
      chk_bit(irq, tbl[k][5] & tbl[k][6]);
    end
    $display("test flag done");
    // clock enable low must swallow a register write
    @(posedge clk);
    #2 ce = 1'b0;
    sfr_write(CFG_ADDR, CFG_PAGE, 8'hE3);
    ce = 1'b1;
    sfr_read(CFG_ADDR, CFG_PAGE, d, v);
    chk_byte(d, CFG_RESET);
    chk_bit(flag, 1'b0);
    $display("test clock enable done");
    // every select code, wrap at the chosen bit only
    pwm_en = '1;
    for (int c = 0; c < 4; c++) begin
      #2 wide_en = NM'($urandom);
      sfr_write(CFG_ADDR, CFG_PAGE, 8'h40 | 8'(c));
      idle(2);
      for (int n = 0; n < NM; n++) begin
        chk_byte({3'h0, bits_out[5*n +: 5]}, {3'h0, bits_exp(2'(c), wide_en[n])});
      end
      m = mask_of(2'(c));
      tick((16'($urandom) & ~m) | (m >> 1));
      chk_bit(flag, 1'b0);
      tick((16'($urandom) & ~m) | m);
      chk_bit(flag, 1'b1);
      chk_bit(irq, 1'b1);
      sfr_write(CFG_ADDR, CFG_PAGE, 8'(c));
      idle(2);
      chk_bit(flag, 1'b0);
    end
    $display("test cycle length done");
    #2 pwm_en = '0;
    wide_en = '0;
    sfr_write(CFG_ADDR, CFG_PAGE, 8'h00);
    for (int n = 0; n < NM; n++) begin
      cmp_exp[n] = 16'($urandom);
      wr_word(n, cmp_exp[n]);
    end
    sfr_write(CFG_ADDR, CFG_PAGE, 8'h80);
    for (int n = 0; n < NM; n++) begin
      arl_exp[n] = 16'($urandom);
      wr_word(n, arl_exp[n]);
    end
    for (int n = 0; n < NM; n++) begin
      rd_word(n, rw);
      chk_word(rw, arl_exp[n]);
      chk_word(cmp_out[16*n +: 16], cmp_exp[n]);
    end
    sfr_write(CFG_ADDR, CFG_PAGE, 8'h00);
    for (int n = 0; n < NM; n++) begin
      rd_word(n, rw);
      chk_word(rw, cmp_exp[n]);
    end
    $display("test steering done");
    // reload bank inert in 8-bit cycle
    #2 pwm_en = '1;
    tick(16'h00FF);
    for (int n = 0; n < NM; n++) begin
      chk_word(cmp_out[16*n +: 16], cmp_exp[n]);
    end
    // reload at 9-bit wrap for narrow pwm modules only
    sfr_write(CFG_ADDR, CFG_PAGE, 8'h01);
    #2 pwm_en = 6'b011011;
    wide_en = 6'b010001;
    tick(16'h01FF | (16'($urandom) & 16'hFE00));
    for (int n = 0; n < NM; n++) begin
      chk_word(cmp_out[16*n +: 16], (pwm_en[n] & ~wide_en[n]) ? arl_exp[n] : cmp_exp[n]);
    end
    $display("test reload done");
    end_sim();
  end
endmodule : pcc_pwm_cycle_config_bench
